// file: rfsb_bank.sv
// Purpose: Regulator fault status, summary flags and mask registers.
// Assumes: Condition inputs and the register port are synchronous to clock_i.
// Notes: Status bits mirror live faults; writes to status registers are ignored.
`timescale 1ns/1ps
// Function
// - Status c holds eight regulator fault bits, reset zero.
// - Status d holds four regulator fault bits, bits 7:4 reserved, reset zero.
// - Status b bits 3..7 report five further regulators.
// - A fault bit reads one while its regulator has a fault.
// - Read-only summary flag register resets zero, bits 7:3 reserved.
// - Summary bit 0 reports the thermal warning.
// - Summary bit 1 is any regulator fault or battery over-current.
// - Summary bit 2 regulator failure flag, same cause as bit 1.
// - Mask register is read-write and resets to 0x03.
// - Mask bit one masks the flag at the same position.
// - Each regulator fault is the OR of its conditions.
// - All regulator faults OR into the battery/regulator flag.
// - An unmasked active flag raises the interrupt output.
module rfsb_bank
  import rfsb_pkg::*;
#(
  parameter int unsigned NREG = NUM_REGS
)(
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire rfsb_cond_t [NREG-1:0] cond_i,
  input wire logic thermal_warning_i,
  input wire logic battery_overcurrent_i,
  input wire rfsb_req_t req_i,
  output logic [7:0] rdata_o,
  output logic rvalid_o,
  output logic first_level_fault_interrupt_o,
  output logic device_interrupt_out_o
);
  logic [NREG-1:0] fault;
  logic [7:0] status_b_r;
  logic [7:0] status_c_r;
  logic [7:0] status_d_r;
  logic [7:0] summary_r;
  logic [7:0] mask_r;
  logic [7:0] rdata_r;
  logic rvalid_r;
  logic irq_r;
  logic any_fault;
  logic [7:0] summary_nxt;

  genvar g;
  for (g = 0; g < NREG; g++) begin : g_or
    rfsb_fault_or u_or (
      .cond_i(cond_i[g]),
      .fault_o(fault[g])
    );
  end

  // Battery over-current shares this flag; only the status registers name the regulator.
  assign any_fault = (|fault) | battery_overcurrent_i;

  always_comb begin
    summary_nxt = RST_FLAG_SUMMARY;
    summary_nxt[BIT_THERMAL] = thermal_warning_i;
    summary_nxt[BIT_BATREG] = any_fault;
    summary_nxt[BIT_REG_FAIL] = any_fault;
  end

  // Fault bits are live copies, so a status write cannot hide a present fault.
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      status_b_r <= RST_STATUS;
      status_c_r <= RST_STATUS;
      status_d_r <= RST_STATUS;
    end else begin
      status_b_r <= {fault[4:0], 3'b000} & STATUS_B_BITS;
      status_c_r <= fault[12:5];
      status_d_r <= {4'h0, fault[16:13]} & STATUS_D_BITS;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      summary_r <= RST_FLAG_SUMMARY;
    end else begin
      summary_r <= summary_nxt;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      mask_r <= RST_FLAG_MASK;
    end else if (req_i.wr && req_i.addr == OFS_FLAG_MASK) begin
      mask_r <= req_i.wdata & MASK_FIELD_BITS;
    end
  end

  // Registered so the interrupt line cannot glitch while the summary settles.
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(summary_r & ~mask_r & MASK_FIELD_BITS);
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= req_i.rd;
      // Read data is loaded only on a read and then held, so the host may take it late.
      if (req_i.rd) begin
        case (req_i.addr)
          OFS_FLAG_SUMMARY: rdata_r <= summary_r;
          OFS_FLAG_MASK: rdata_r <= mask_r;
          OFS_STATUS_B: rdata_r <= status_b_r;
          OFS_STATUS_C: rdata_r <= status_c_r;
          OFS_STATUS_D: rdata_r <= status_d_r;
          default: rdata_r <= 8'h00;
        endcase
      end
    end
  end

  assign rdata_o = rdata_r;
  assign rvalid_o = rvalid_r;
  assign first_level_fault_interrupt_o = irq_r;
  assign device_interrupt_out_o = irq_r;

  property p_batreg_flag;
    @(posedge clock_i) disable iff (!rst_b_i)
      any_fault |=> summary_r[BIT_BATREG] && summary_r[BIT_REG_FAIL];
  endproperty
  a_batreg_flag: assert property (p_batreg_flag) else $error("fault flag not set");

  property p_thermal;
    @(posedge clock_i) disable iff (!rst_b_i)
      ##1 summary_r[BIT_THERMAL] == $past(thermal_warning_i);
  endproperty
  a_thermal: assert property (p_thermal) else $error("thermal flag wrong");

  property p_reserved_summary;
    @(posedge clock_i) disable iff (!rst_b_i)
      summary_r[7:3] == 5'h00 && mask_r[7:3] == 5'h00 && status_d_r[7:4] == 4'h0;
  endproperty
  a_reserved_summary: assert property (p_reserved_summary) else $error("reserved set");

  property p_irq;
    @(posedge clock_i) disable iff (!rst_b_i)
      (summary_r[BIT_REG_FAIL] && !mask_r[BIT_REG_FAIL]) |=> device_interrupt_out_o;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missing");

  property p_masked;
    @(posedge clock_i) disable iff (!rst_b_i)
      ((summary_r & ~mask_r & MASK_FIELD_BITS) == 8'h00) |=> !device_interrupt_out_o;
  endproperty
  a_masked: assert property (p_masked) else $error("masked flag interrupts");

  property p_status_c;
    @(posedge clock_i) disable iff (!rst_b_i)
      ##1 status_c_r == $past(fault[12:5]);
  endproperty
  a_status_c: assert property (p_status_c) else $error("status c mismatch");

  property p_status_b;
    @(posedge clock_i) disable iff (!rst_b_i)
      ##2 status_b_r[2:0] == 3'b000 && status_b_r[7:3] == $past(fault[4:0], 1);
  endproperty
  a_status_b: assert property (p_status_b) else $error("status b mismatch");

  property p_status_d;
    @(posedge clock_i) disable iff (!rst_b_i)
      ##1 status_d_r[3:0] == $past(fault[16:13]);
  endproperty
  a_status_d: assert property (p_status_d) else $error("status d mismatch");

  property p_mask_reset;
    @(posedge clock_i) !rst_b_i |=> mask_r == RST_FLAG_MASK && summary_r == 8'h00;
  endproperty
  a_mask_reset: assert property (p_mask_reset) else $error("reset value wrong");

  property p_flag_clear;
    @(posedge clock_i) disable iff (!rst_b_i)
      !any_fault |=> !summary_r[BIT_BATREG] && !summary_r[BIT_REG_FAIL];
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("fault flag stuck");

  property p_any_unmasked;
    @(posedge clock_i) disable iff (!rst_b_i)
      (|(summary_r & ~mask_r & MASK_FIELD_BITS)) |=> device_interrupt_out_o;
  endproperty
  a_any_unmasked: assert property (p_any_unmasked) else $error("unmasked flag silent");

  property p_mask_write;
    @(posedge clock_i) disable iff (!rst_b_i)
      req_i.wr && req_i.addr == OFS_FLAG_MASK
        |=> mask_r == ($past(req_i.wdata) & MASK_FIELD_BITS);
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask write lost");

  property p_mask_hold;
    @(posedge clock_i) disable iff (!rst_b_i)
      !(req_i.wr && req_i.addr == OFS_FLAG_MASK) |=> mask_r == $past(mask_r);
  endproperty
  a_mask_hold: assert property (p_mask_hold) else $error("mask changed");

  property p_read_summary;
    @(posedge clock_i) disable iff (!rst_b_i)
      req_i.rd && req_i.addr == OFS_FLAG_SUMMARY |=> rdata_o == $past(summary_r);
  endproperty
  a_read_summary: assert property (p_read_summary) else $error("summary read");

  property p_read_mask;
    @(posedge clock_i) disable iff (!rst_b_i)
      req_i.rd && req_i.addr == OFS_FLAG_MASK |=> rdata_o == $past(mask_r);
  endproperty
  a_read_mask: assert property (p_read_mask) else $error("mask read");

  property p_read_status_c;
    @(posedge clock_i) disable iff (!rst_b_i)
      req_i.rd && req_i.addr == OFS_STATUS_C |=> rdata_o == $past(status_c_r);
  endproperty
  a_read_status_c: assert property (p_read_status_c) else $error("status c read");

  property p_read_status_d;
    @(posedge clock_i) disable iff (!rst_b_i)
      req_i.rd && req_i.addr == OFS_STATUS_D |=> rdata_o == $past(status_d_r);
  endproperty
  a_read_status_d: assert property (p_read_status_d) else $error("status d read");
endmodule

// file: rfsb_fault_or.sv
// Purpose: Folds the fault conditions of one regulator into its fault signal.
// Assumes: Conditions are synchronous to clock_i.
// Notes: Purely combinational.
`timescale 1ns/1ps
module rfsb_fault_or
  import rfsb_pkg::*;
(
  input wire rfsb_cond_t cond_i,
  output logic fault_o
);
  // Unsupported conditions are tied low by the instantiating level.
  assign fault_o = cond_i.under_voltage | cond_i.over_voltage |
                   cond_i.over_current | cond_i.short_circuit;
endmodule

// file: rfsb_host_model.sv
// Purpose: System controller model that reads and writes the bank registers.
// Assumes: Called just after a rising edge; one request per call.
// Notes: A read waits a bounded time for the data valid pulse.
`timescale 1ns/1ps
module rfsb_host_model
  import rfsb_pkg::*;
(
  input wire logic clock_i,
  input wire logic [7:0] rdata_i,
  input wire logic rvalid_i,
  output rfsb_req_t req_o
);
  int timeouts = 0;
  initial req_o = '0;
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    req_o = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock_i);
    #1 req_o = '0;
    @(posedge clock_i);
    #1;
  endtask
  task automatic rd(input logic [8:0] a, output logic [7:0] d);
    int n;
    req_o = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clock_i);
    #1 req_o = '0;
    n = 0;
    while (rvalid_i !== 1'b1 && n < 4) begin
      @(posedge clock_i);
      #1 n++;
    end
    d = rdata_i;
    if (rvalid_i !== 1'b1) timeouts++;
    @(posedge clock_i);
    #1;
  endtask
endmodule

// file: rfsb_pkg.sv
// Purpose: Shared constants and carrier types for the regulator fault status bank.
// Assumes: Eight-bit registers behind a documented register port with a 9-bit address.
// Notes: Offsets are the printed register addresses.
package rfsb_pkg;
  localparam int unsigned ADDR_W = 9;
  localparam logic [8:0] OFS_FLAG_SUMMARY = 9'h030;
  localparam logic [8:0] OFS_FLAG_MASK = 9'h031;
  localparam logic [8:0] OFS_STATUS_B = 9'h1cd;
  localparam logic [8:0] OFS_STATUS_C = 9'h1ce;
  localparam logic [8:0] OFS_STATUS_D = 9'h1cf;
  localparam logic [7:0] RST_FLAG_SUMMARY = 8'h00;
  localparam logic [7:0] RST_FLAG_MASK = 8'h03;
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [7:0] MASK_FIELD_BITS = 8'h07;
  localparam logic [7:0] STATUS_B_BITS = 8'hf8;
  localparam logic [7:0] STATUS_D_BITS = 8'h0f;
  localparam int unsigned BIT_THERMAL = 0;
  localparam int unsigned BIT_BATREG = 1;
  localparam int unsigned BIT_REG_FAIL = 2;
  localparam int unsigned NUM_REGS = 17;

  // Per-regulator fault conditions; a regulator that lacks one ties it low.
  typedef struct packed {
    logic under_voltage;
    logic over_voltage;
    logic over_current;
    logic short_circuit;
  } rfsb_cond_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [8:0] addr;
    logic [7:0] wdata;
  } rfsb_req_t;
endpackage

// file: tb_rfsb_bank.sv
// Purpose: Self-checking bench for the regulator fault status bank.
// Assumes: Inputs change 1 ns after a rising edge.
// Notes: Interrupt is judged two cycles after its cause settles.
`timescale 1ns/1ps
module tb_rfsb_bank;
  import rfsb_pkg::*;
  logic clock_i = 0;
  logic rst_b_i = 0;
  rfsb_cond_t [NUM_REGS-1:0] cond = '0;
  logic therm = 0;
  logic bat = 0;
  rfsb_req_t req;
  logic [7:0] rdata;
  logic rvalid, irq1, irq2;
  int mismatches = 0;
  int checks = 0;
  rfsb_bank dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .cond_i(cond), .thermal_warning_i(therm),
    .battery_overcurrent_i(bat), .req_i(req), .rdata_o(rdata), .rvalid_o(rvalid),
    .first_level_fault_interrupt_o(irq1), .device_interrupt_out_o(irq2));
  rfsb_host_model host (.clock_i(clock_i), .rdata_i(rdata), .rvalid_i(rvalid), .req_o(req));
  initial forever #25 clock_i = ~clock_i;
  task automatic conclude();
    if (mismatches == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [8:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host.rd(a, d);
    if (host.timeouts != 0) begin
      mismatches++;
      conclude();
    end else begin
      chk(d, exp);
    end
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic s_reset();
    rchk(OFS_FLAG_SUMMARY, RST_FLAG_SUMMARY);
    rchk(OFS_FLAG_MASK, RST_FLAG_MASK);
    rchk(OFS_STATUS_C, RST_STATUS);
    rchk(OFS_STATUS_D, RST_STATUS);
    rchk(OFS_STATUS_B, RST_STATUS);
    rchk(9'h100, 8'h00);
    chk({6'h0, irq1, irq2}, 8'h00);
  endtask
  task automatic s_map();
    logic [8:0] a;
    int b;
    for (int i = 0; i < NUM_REGS; i++) begin
      for (int k = 0; k < 4; k++) begin
        a = i < 5 ? OFS_STATUS_B : (i < 13 ? OFS_STATUS_C : OFS_STATUS_D);
        b = i < 5 ? i + 3 : (i < 13 ? i - 5 : i - 13);
        cond[i] = 4'b1000 >> k;
        cycles(1);
        rchk(a, 8'h01 << b);
        rchk(OFS_FLAG_SUMMARY, 8'h06);
        cond[i] = '0;
        cycles(1);
        rchk(a, 8'h00);
        rchk(OFS_FLAG_SUMMARY, 8'h00);
      end
    end
  endtask
  task automatic s_flags();
    therm = 1;
    cycles(3);
    rchk(OFS_FLAG_SUMMARY, 8'h01);
    chk({6'h0, irq1, irq2}, 8'h00);
    host.wr(OFS_FLAG_MASK, 8'hfe);
    rchk(OFS_FLAG_MASK, 8'h06);
    cycles(2);
    chk({6'h0, irq1, irq2}, 8'h03);
    host.wr(OFS_FLAG_MASK, 8'h07);
    therm = 0;
    bat = 1;
    host.wr(OFS_FLAG_SUMMARY, 8'h00);
    host.wr(OFS_STATUS_C, 8'hff);
    rchk(OFS_FLAG_SUMMARY, 8'h06);
    rchk(OFS_STATUS_C, 8'h00);
    chk({6'h0, irq1, irq2}, 8'h00);
    host.wr(OFS_FLAG_MASK, 8'h03);
    cycles(2);
    chk({6'h0, irq1, irq2}, 8'h03);
    host.wr(OFS_FLAG_MASK, 8'h05);
    cycles(2);
    chk({6'h0, irq1, irq2}, 8'h03);
    bat = 0;
    cycles(3);
    chk({6'h0, irq1, irq2}, 8'h00);
  endtask
  task automatic s_rereset();
    host.wr(OFS_FLAG_MASK, 8'h00);
    rchk(OFS_FLAG_MASK, 8'h00);
    rst_b_i = 0;
    cycles(2);
    rst_b_i = 1;
    rchk(OFS_FLAG_MASK, RST_FLAG_MASK);
    rchk(OFS_FLAG_SUMMARY, RST_FLAG_SUMMARY);
    chk({6'h0, irq1, irq2}, 8'h00);
  endtask
  initial begin
    repeat (16) @(posedge clock_i);
    #1 rst_b_i = 1;
    s_reset();
    s_map();
    s_flags();
    s_rereset();
    conclude();
  end
endmodule
